// >>> src/rsq_pkg.sv
// Constants, types and register map of the reset sequencer.
// Assumes a 10 MHz system clock and a 32-bit APB register port.
package rsq_pkg;

  // Clock rate
  localparam int CLK_PERIOD_NS = 100;

  // Reset sequence timing
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam int FETCH_CYC = 2;
  localparam int RST_OUT_MIN_NS = 20000;
  localparam int PLL_START_NS_DEF = 1000000;

  // Reset vector location
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFF;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h04;

  // Integrity status register fields
  localparam int BIT_DOG = 4;
  localparam int BIT_LOWSUP = 2;
  localparam int BIT_EWF = 1;
  localparam int BIT_EWIE = 0;

  // Phase register fields
  localparam int PH_STATE_LSB = 0;
  localparam int PH_PIN_BIT = 8;
  localparam int PH_CLK_BIT = 9;

  // Detector threshold codes
  localparam logic [1:0] THR_LOW = 2'h0;
  localparam logic [1:0] THR_MED = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;

  typedef enum logic [4:0]
  {
    ST_RUN = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_DELAY = 5'h04,
    ST_PLL = 5'h08,
    ST_FETCH = 5'h10
  } rsq_state_type;

  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rsq_apb_req_type;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsq_apb_rsp_type;

  // Option byte image
  typedef struct packed
  {
    logic lvd_en;
    logic xtal_sel;
    logic pll_en;
    logic [1:0] lvd_thr;
  } rsq_opt_type;

endpackage

// >>> src/rsq_sync.sv
// Two-stage synchroniser with a constant reset value.
// Assumes arst_n may come from a pin; it clears both stages at once.
`timescale 1ns/1ps
module rsq_sync
  import rsq_pkg::*;
#(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= {W{RST_VAL}};
      q <= {W{RST_VAL}};
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// >>> src/rsq_top.sv
// Reset sequencer and supply integrity monitor.
// Assumes static option byte inputs and APB master on sys_clk.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rsq_top
  import rsq_pkg::*;
#(
  parameter int DELAY_SHORT = DELAY_SHORT_CYC,
  parameter int DELAY_LONG = DELAY_LONG_CYC,
  parameter int PLL_START_NS = PLL_START_NS_DEF,
  parameter int RST_OUT_NS = RST_OUT_MIN_NS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register bus
  input wire rsq_apb_req_type apb_req,
  output rsq_apb_rsp_type apb_rsp,
  // Open-drain reset pin
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // Reset causes and analog comparators
  input wire logic wdg_underflow,
  input wire logic illegal_op,
  input wire logic supply_low_cmp,
  input wire logic early_warn_cmp,
  // Option byte
  input wire rsq_opt_type opt,
  // CPU side
  input wire logic cpu_imask,
  input wire logic irq_ack,
  input wire logic halt_mode,
  input wire logic wait_mode,
  output logic core_rst_n,
  output logic vec_fetch,
  output logic [15:0] vec_addr,
  output logic clk_out_en,
  output logic early_warning_irq,
  output logic wait_wake,
  // Detector configuration
  output logic det_en,
  output logic [1:0] det_thr
);

  localparam int RST_CYC = (RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_CYC = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_MAX = (DELAY_LONG > PLL_CYC) ? DELAY_LONG : PLL_CYC;
  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam int HOLD_W = $clog2(RST_CYC + 1);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic ext_q;
  logic low_s;
  logic ew_s;
  logic rst_pin_oe_reg;
  logic ext_arst_n;

  // Own drive must not read back as an external reset
  assign ext_arst_n = nrst & (rst_pin_in | rst_pin_oe_reg);

  // Release retimed to sys_clk before the sequence advances
  rsq_sync #(.W(1), .RST_VAL(1'b0)) u_pin_sync
  (
    .clk(sys_clk),
    .arst_n(ext_arst_n),
    .d(1'b1),
    .q(ext_q)
  );

  rsq_sync #(.W(2), .RST_VAL(1'b0)) u_cmp_sync
  (
    .clk(sys_clk),
    .arst_n(nrst),
    .d({supply_low_cmp, early_warn_cmp}),
    .q({low_s, ew_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Causes

  rsq_state_type state_reg;
  rsq_state_type state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] cnt_load;
  logic [CNT_W-1:0] dly_sel;
  logic [HOLD_W-1:0] hold_reg;
  logic [HOLD_W-1:0] hold_next;
  logic ext_req;
  logic lvd_low;
  logic ew_live;
  logic pulse_cause;
  logic any_cause;
  logic hold_busy;
  logic cnt_zero;

  assign ext_req = ~ext_q;
  assign lvd_low = opt.lvd_en & low_s;
  assign ew_live = opt.lvd_en & ew_s;
  assign pulse_cause = wdg_underflow | illegal_op;
  assign any_cause = ext_req | lvd_low | pulse_cause;
  assign hold_busy = (hold_reg != '0);
  assign cnt_zero = (cnt_reg == '0);

  // Watchdog and opcode resets are pulses, so stretch them
  assign hold_next = pulse_cause ? HOLD_W'(RST_CYC) :
                     (hold_busy ? hold_reg - 1'b1 : hold_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // A new cause in any phase restarts from the active phase
  always_comb
  begin
    state_next = state_reg;
    if (any_cause)
      state_next = ST_ACTIVE;
    else
      unique case (state_reg)
        ST_RUN: state_next = ST_RUN;
        ST_ACTIVE: state_next = hold_busy ? ST_ACTIVE : ST_DELAY;
        ST_DELAY: state_next = !cnt_zero ? ST_DELAY : (opt.pll_en ? ST_PLL : ST_FETCH);
        ST_PLL: state_next = cnt_zero ? ST_FETCH : ST_PLL;
        ST_FETCH: state_next = cnt_zero ? ST_RUN : ST_FETCH;
        default: state_next = ST_ACTIVE;
      endcase
  end

  assign dly_sel = opt.xtal_sel ? CNT_W'(DELAY_LONG) : CNT_W'(DELAY_SHORT);
  assign cnt_load = (state_next == ST_DELAY) ? dly_sel - 1'b1 :
                    (state_next == ST_PLL) ? CNT_W'(PLL_CYC - 1) :
                    (state_next == ST_FETCH) ? CNT_W'(FETCH_CYC - 1) : '0;
  assign cnt_next = (state_next != state_reg) ? cnt_load :
                    (cnt_zero ? cnt_reg : cnt_reg - 1'b1);

  // Pin and CPU-side outputs
  logic drive_next;
  logic clk_en_next;
  logic [15:0] vec_addr_next;
  logic core_rst_n_reg;
  logic vec_fetch_reg;
  logic [15:0] vec_addr_reg;
  logic clk_out_en_reg;
  logic rst_pin_out_reg;

  assign drive_next = (state_next == ST_DELAY) |
                      ((state_next == ST_ACTIVE) & (lvd_low | pulse_cause | hold_busy));
  assign clk_en_next = ~opt.pll_en | (state_next == ST_FETCH) | (state_next == ST_RUN);
  assign vec_addr_next = (state_reg == ST_FETCH) ? VEC_ADDR_LO : VEC_ADDR_HI;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_ACTIVE;
      cnt_reg <= '0;
      hold_reg <= '0;
      rst_pin_oe_reg <= 1'b0;
      rst_pin_out_reg <= 1'b0;
      core_rst_n_reg <= 1'b0;
      vec_fetch_reg <= 1'b0;
      vec_addr_reg <= VEC_ADDR_HI;
      clk_out_en_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      rst_pin_oe_reg <= drive_next;
      rst_pin_out_reg <= 1'b0;
      core_rst_n_reg <= (state_next == ST_RUN);
      vec_fetch_reg <= (state_next == ST_FETCH);
      vec_addr_reg <= vec_addr_next;
      clk_out_en_reg <= clk_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  rsq_apb_rsp_type rsp_reg;
  rsq_apb_rsp_type rsp_next;
  logic setup;
  logic done;
  logic sel_status;
  logic sel_phase;
  logic wr_status;
  logic rd_status;
  logic frz;
  logic [31:0] status_rd;
  logic [31:0] phase_rd;
  logic dog_flag_reg;
  logic low_flag_reg;
  logic ie_reg;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign done = apb_req.psel & apb_req.penable & rsp_reg.pready;
  assign sel_status = addr_hit(apb_req.paddr, OFS_STATUS);
  assign sel_phase = addr_hit(apb_req.paddr, OFS_PHASE);
  assign frz = halt_mode;
  assign wr_status = done & apb_req.pwrite & sel_status & ~frz;
  assign rd_status = done & ~apb_req.pwrite & sel_status & ~frz;

  always_comb
  begin
    status_rd = '0;
    status_rd[BIT_DOG] = dog_flag_reg;
    status_rd[BIT_LOWSUP] = low_flag_reg;
    status_rd[BIT_EWF] = ew_live;
    status_rd[BIT_EWIE] = ie_reg;
    phase_rd = '0;
    phase_rd[PH_STATE_LSB +: 5] = state_reg;
    phase_rd[PH_PIN_BIT] = rst_pin_oe_reg;
    phase_rd[PH_CLK_BIT] = clk_out_en_reg;
  end

  assign rsp_next.pready = setup;
  assign rsp_next.pslverr = setup & ~(sel_status | sel_phase);
  assign rsp_next.prdata = ~setup ? rsp_reg.prdata :
                           sel_status ? status_rd :
                           sel_phase ? phase_rd : '0;

  // Read-clear only drops bits the read returned, so a late set survives
  logic dog_next;
  logic low_next;
  logic ie_next;

  assign dog_next = lvd_low ? 1'b0 :
                    wdg_underflow ? 1'b1 :
                    ((rd_status & rsp_reg.prdata[BIT_DOG]) |
                     (wr_status & ~apb_req.pwdata[BIT_DOG])) ? 1'b0 : dog_flag_reg;
  assign low_next = lvd_low ? 1'b1 :
                    (rd_status & rsp_reg.prdata[BIT_LOWSUP]) ? 1'b0 : low_flag_reg;
  assign ie_next = (state_reg != ST_RUN) ? 1'b0 :
                   wr_status ? apb_req.pwdata[BIT_EWIE] : ie_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Early-warning interrupt

  logic ew_prev_reg;
  logic pend_reg;
  logic ew_rise;
  logic pend_next;
  logic irq_next;
  logic wake_next;
  logic irq_reg;
  logic wake_reg;
  logic det_en_reg;
  logic [1:0] det_thr_reg;

  assign ew_rise = ew_live & ~ew_prev_reg;
  assign pend_next = (state_reg != ST_RUN) ? 1'b0 :
                     ew_rise ? 1'b1 :
                     irq_ack ? 1'b0 : pend_reg;
  assign irq_next = pend_next & ie_reg & ~cpu_imask;
  assign wake_next = irq_next & wait_mode & ~halt_mode;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_reg <= '0;
      dog_flag_reg <= 1'b0;
      low_flag_reg <= 1'b0;
      ie_reg <= 1'b0;
      ew_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      det_en_reg <= 1'b0;
      det_thr_reg <= THR_LOW;
    end
    else
    begin
      rsp_reg <= rsp_next;
      dog_flag_reg <= dog_next;
      low_flag_reg <= low_next;
      ie_reg <= ie_next;
      ew_prev_reg <= ew_live;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      det_en_reg <= opt.lvd_en;
      det_thr_reg <= opt.lvd_thr;
    end
  end

  assign apb_rsp = rsp_reg;
  assign rst_pin_oe = rst_pin_oe_reg;
  assign rst_pin_out = rst_pin_out_reg;
  assign core_rst_n = core_rst_n_reg;
  assign vec_fetch = vec_fetch_reg;
  assign vec_addr = vec_addr_reg;
  assign clk_out_en = clk_out_en_reg;
  assign early_warning_irq = irq_reg;
  assign wait_wake = wake_reg;
  assign det_en = det_en_reg;
  assign det_thr = det_thr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [CNT_W-1:0] dly_obs;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      dly_obs <= '0;
    else
      dly_obs <= (state_reg == ST_DELAY) ? dly_obs + 1'b1 : '0;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_pin_delay;
    state_reg == ST_DELAY |-> rst_pin_oe_reg && !rst_pin_out_reg;
  endproperty
  a_pin_delay: assert property (p_pin_delay) else $error("pin not low in delay");

  property p_delay_len;
    state_reg == ST_DELAY && (state_next == ST_PLL || state_next == ST_FETCH)
      |-> dly_obs == dly_sel - 1'b1;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay length wrong");

  property p_fetch_enter;
    state_reg == ST_FETCH && $past(state_reg) != ST_FETCH && !any_cause
      |=> state_reg == ST_FETCH;
  endproperty
  a_fetch_enter: assert property (p_fetch_enter) else $error("fetch too short");

  property p_fetch_leave;
    state_reg == ST_FETCH && $past(state_reg) == ST_FETCH |=> state_reg != ST_FETCH;
  endproperty
  a_fetch_leave: assert property (p_fetch_leave) else $error("fetch too long");

  property p_vec;
    $rose(vec_fetch_reg) |-> vec_addr_reg == VEC_ADDR_HI
      ##1 (!vec_fetch_reg || vec_addr_reg == VEC_ADDR_LO);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");

  property p_wdg_load;
    wdg_underflow |=> hold_reg == HOLD_W'(RST_CYC) && rst_pin_oe_reg;
  endproperty
  a_wdg_load: assert property (p_wdg_load) else $error("watchdog pulse not started");

  property p_hold_pin;
    hold_reg != '0 |-> state_reg == ST_ACTIVE && rst_pin_oe_reg;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("pulse cut short");

  property p_lvd;
    lvd_low |=> state_reg == ST_ACTIVE && rst_pin_oe_reg && !core_rst_n_reg;
  endproperty
  a_lvd: assert property (p_lvd) else $error("low supply not in reset");

  property p_dog;
    wdg_underflow && !lvd_low && !rd_status |=> dog_flag_reg && low_flag_reg == $past(low_flag_reg);
  endproperty
  a_dog: assert property (p_dog) else $error("dog flag not set");

  property p_low;
    lvd_low |=> low_flag_reg && !dog_flag_reg;
  endproperty
  a_low: assert property (p_low) else $error("low supply flags wrong");

  property p_irq;
    ew_rise && ie_reg && !cpu_imask && state_reg == ST_RUN |=> irq_reg;
  endproperty
  a_irq: assert property (p_irq) else $error("early warning irq missing");

  property p_ack;
    irq_ack && !ew_rise |=> !pend_reg && !irq_reg;
  endproperty
  a_ack: assert property (p_ack) else $error("pending not cleared");

  property p_halt;
    halt_mode |=> !wake_reg && $stable(ie_reg) || $past(state_reg) != ST_RUN;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not respected");

  property p_pll;
    state_reg == ST_PLL |-> !clk_out_en_reg;
  endproperty
  a_pll: assert property (p_pll) else $error("clock out during pll start");

  property p_ext;
    !ext_q |=> state_reg == ST_ACTIVE && !core_rst_n_reg;
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset missed");

  c_wdg: cover property (wdg_underflow ##1 state_reg == ST_ACTIVE);
  c_long: cover property (state_reg == ST_DELAY && opt.xtal_sel);
  c_fetch: cover property ($rose(vec_fetch_reg));
  c_irq: cover property ($rose(irq_reg));

endmodule

// >>> sim/rsq_board.sv
// Board model of the reset pin: weak pull-up plus an external reset switch.
// Assumes rst_pin_oe is high while the device sinks the pin.
`timescale 1ns/1ps
module rsq_board
  import rsq_pkg::*;
(
  // Device side
  input wire logic rst_pin_oe,
  // Board switch, may hold the pin low while memory is blank
  input wire logic ext_low,
  // Resolved wire
  output logic rst_pin_in
);
  // Combinational, else a released pin would loop back into reset
  assign rst_pin_in = (rst_pin_oe | ext_low) ? 1'b0 : 1'b1;
endmodule

// >>> sim/test_rsq_top.sv
// Self-checking bench of the reset sequencer, one task per scenario.
// Assumes rsq_board resolves the reset pin; sequence counts are shortened.
`timescale 1ns/1ps
module test_rsq_top;
  import rsq_pkg::*;
  localparam int DS = 8;
  localparam int DL = 16;
  localparam int PLL_CYC = 20;
  localparam int OUT_CYC = 5;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ext_low = 1'b1;
  rsq_apb_req_type apb_req = '0;
  rsq_apb_rsp_type apb_rsp;
  rsq_opt_type opt = 5'h11;
  logic rst_pin_in, rst_pin_oe, core_rst_n, vec_fetch, clk_out_en, early_warning_irq;
  logic wait_wake, det_en, rst_pin_out;
  logic [1:0] det_thr;
  logic [15:0] vec_addr;
  logic wdg_underflow = 1'b0, illegal_op = 1'b0, supply_low_cmp = 1'b0, early_warn_cmp = 1'b0;
  logic cpu_imask = 1'b1, irq_ack = 1'b0, halt_mode = 1'b0, wait_mode = 1'b0;
  int errors = 0;
  int comparisons = 0;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  rsq_top #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .PLL_START_NS(2000), .RST_OUT_NS(500)) rsq_top_i
  (
    .sys_clk(sys_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .wdg_underflow(wdg_underflow), .illegal_op(illegal_op), .supply_low_cmp(supply_low_cmp),
    .early_warn_cmp(early_warn_cmp), .opt(opt), .cpu_imask(cpu_imask), .irq_ack(irq_ack),
    .halt_mode(halt_mode), .wait_mode(wait_mode), .core_rst_n(core_rst_n),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr), .clk_out_en(clk_out_en),
    .early_warning_irq(early_warning_irq), .wait_wake(wait_wake), .det_en(det_en),
    .det_thr(det_thr)
  );
  rsq_board rsq_board_i (.rst_pin_oe(rst_pin_oe), .ext_low(ext_low), .rst_pin_in(rst_pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    chk(n < 20, "no pready");
    apb_req <= '0;
  endtask

  // Waits for the vector fetch, counting cycles and cycles with the pin driven
  task automatic run_out(input int lim, output int n, output int k);
    n = 0;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (rst_pin_oe === 1'b1) k++;
    end
    while (vec_fetch !== 1'b1 && n < lim);
    chk(vec_fetch === 1'b1 && vec_addr === VEC_ADDR_HI && core_rst_n === 1'b0, "fetch 1");
    @(posedge sys_clk);
    chk(vec_fetch === 1'b1 && vec_addr === VEC_ADDR_LO, "fetch 2");
    @(posedge sys_clk);
    chk(vec_fetch === 1'b0 && core_rst_n === 1'b1, "fetch end");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    int n, k;
    logic [31:0] rd;
    logic e;
    run_out(100, n, k);
    apb(1'b0, OFS_PHASE, 32'h0, rd, e);
    chk(rd === 32'h00000201 && e === 1'b0 && rst_pin_out === 1'b0, "phase");
    chk(k >= DS && k <= DS + 2, "short delay pin");
    chk(n >= DS && n <= DS + 6, "short delay");
    chk(det_en === 1'b1 && det_thr === THR_MED && clk_out_en === 1'b1, "options");
  endtask

  task automatic t_dog();
    int n, k, v;
    logic [31:0] rd;
    logic e;
    for (v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      wdg_underflow <= 1'b1;
      @(posedge sys_clk);
      wdg_underflow <= 1'b0;
      run_out(400, n, k);
      chk(k >= OUT_CYC + DS, "dog pulse");
      if (v == 1) apb(1'b1, OFS_STATUS, 32'h0, rd, e);
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(rd[BIT_DOG] === (v == 0), "dog flag");
      apb(1'b0, OFS_STATUS, 32'h0, rd, e);
      chk(rd[BIT_DOG] === 1'b0, "dog clear");
    end
  endtask

  task automatic t_illegal();
    int n, k;
    @(posedge sys_clk);
    illegal_op <= 1'b1;
    @(posedge sys_clk);
    illegal_op <= 1'b0;
    run_out(400, n, k);
    chk(k >= OUT_CYC + DS, "illegal reset");
  endtask

  // Watchdog first, so the supply reset must clear its flag
  task automatic t_supply();
    int n, k;
    @(posedge sys_clk);
    wdg_underflow <= 1'b1;
    @(posedge sys_clk);
    wdg_underflow <= 1'b0;
    run_out(400, n, k);
    supply_low_cmp <= 1'b1;
    repeat (4) @(posedge sys_clk);
    k = 0;
    repeat (30)
    begin
      @(posedge sys_clk);
      if (rst_pin_oe === 1'b1 && core_rst_n === 1'b0) k++;
    end
    chk(k == 30, "supply hold");
    supply_low_cmp <= 1'b0;
    run_out(200, n, k);
  endtask

  task automatic t_ext();
    int n, k;
    logic [31:0] rd;
    logic e;
    ext_low <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(core_rst_n === 1'b0 && vec_fetch === 1'b0, "pin reset");
    ext_low <= 1'b0;
    run_out(200, n, k);
    apb(1'b0, OFS_STATUS, 32'h0, rd, e);
    chk(rd[BIT_LOWSUP] === 1'b1 && rd[BIT_DOG] === 1'b0, "flags kept");
    apb(1'b0, OFS_STATUS, 32'h0, rd, e);
    chk(rd[BIT_LOWSUP] === 1'b0, "lowsup read clear");
  endtask

  task automatic t_warn();
    int n;
    logic [31:0] rd;
    logic e;
    apb(1'b1, OFS_STATUS, 32'h1, rd, e);
    cpu_imask <= 1'b0;
    wait_mode <= 1'b1;
    early_warn_cmp <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (early_warning_irq !== 1'b1 && n < 8);
    chk(early_warning_irq === 1'b1 && wait_wake === 1'b1, "irq wake");
    halt_mode <= 1'b1;
    apb(1'b1, OFS_STATUS, 32'h0, rd, e);
    apb(1'b0, OFS_STATUS, 32'h0, rd, e);
    chk(rd[BIT_EWF] === 1'b1 && rd[BIT_EWIE] === 1'b1, "live flag, frozen");
    halt_mode <= 1'b0;
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(early_warning_irq === 1'b0, "ack clear");
    early_warn_cmp <= 1'b0;
    cpu_imask <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b1, OFS_STATUS, 32'h3, rd, e);
    apb(1'b0, OFS_STATUS, 32'h0, rd, e);
    chk(rd[BIT_EWF] === 1'b0 && rd[BIT_EWIE] === 1'b1, "flag read only");
    early_warn_cmp <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(early_warning_irq === 1'b0, "masked irq");
    early_warn_cmp <= 1'b0;
    apb(1'b0, 8'h10, 32'h0, rd, e);
    chk(e === 1'b1 && rd === 32'h0, "unmapped");
  endtask

  task automatic t_long();
    int n, k;
    opt <= 5'h1D;
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (DL + 4) @(posedge sys_clk);
    chk(clk_out_en === 1'b0, "pll clock held");
    run_out(200, n, k);
    chk(n + DL + 4 >= DL + PLL_CYC && clk_out_en === 1'b1, "long delay");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    ext_low <= 1'b0;
    t_power();
    t_dog();
    t_illegal();
    t_supply();
    t_ext();
    t_warn();
    t_long();
    give_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    give_verdict();
  end
endmodule
